// file: design/dsos_params.svh
// Constants of the drive status output selector: offsets, field slices,
// reset values and time bases. Definitions only; included by bare name.
`ifndef DSOS_PARAMS_SVH
`define DSOS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define DSOS_ADDR_W         8
`define DSOS_OFS_SELECT     8'h00
`define DSOS_OFS_ZERO_SPD   8'h04
`define DSOS_OFS_SPD_CMP    8'h08
`define DSOS_OFS_BANDS      8'h0C
`define DSOS_OFS_MAX_SPD    8'h10
`define DSOS_OFS_TIMER      8'h14
`define DSOS_OFS_TEMP       8'h18
`define DSOS_OFS_TRQ_OL     8'h1C
`define DSOS_OFS_LOW_VOLT   8'h20
`define DSOS_OFS_STATUS     8'h24

// ----------------------------------------------------------------------
// Field slices
// ----------------------------------------------------------------------
`define DSOS_F_SEL_R1       4:0
`define DSOS_F_SEL_R2       12:8
`define DSOS_F_SEL_OC       20:16
`define DSOS_F_ZS_LEVEL     12:0
`define DSOS_F_ZS_BAND      22:16
`define DSOS_F_SC_LEVEL     17:0
`define DSOS_F_SC_BAND      30:24
`define DSOS_F_ARR_BAND     6:0
`define DSOS_F_AGR_BAND     14:8
`define DSOS_F_TRQ_BAND     22:16
`define DSOS_F_MAX_SPD      17:0
`define DSOS_F_T_RISE       15:0
`define DSOS_F_T_FALL       31:16
`define DSOS_F_MH_LEVEL     7:0
`define DSOS_F_MH_BAND      11:8
`define DSOS_F_HH_LEVEL     23:16
`define DSOS_F_HH_BAND      27:24
`define DSOS_F_THERM_SEL    31
`define DSOS_F_TRQ_LEVEL    11:0
`define DSOS_F_OL_LEVEL     23:16
`define DSOS_F_OL_TIME      28:24
`define DSOS_F_LV_LEVEL     9:0
`define DSOS_F_ST_FLAGS     17:0
`define DSOS_F_ST_OUTS      26:24

// ----------------------------------------------------------------------
// Reset values of the writable registers
// ----------------------------------------------------------------------
`define DSOS_RST_SELECT     32'h0001_0101
`define DSOS_RST_ZERO_SPD   32'h0005_0064
`define DSOS_RST_SPD_CMP    32'h0500_0000
`define DSOS_RST_BANDS      32'h0005_0505
`define DSOS_RST_MAX_SPD    32'h0000_4650
`define DSOS_RST_TIMER      32'h0001_0001
`define DSOS_RST_TEMP       32'h054B_058C
`define DSOS_RST_TRQ_OL     32'h0A96_0000
`define DSOS_RST_LOW_VOLT   32'h0000_0190

// ----------------------------------------------------------------------
// Scaling and time base
// ----------------------------------------------------------------------
`define DSOS_FUNC_COUNT     18
`define DSOS_FUNC_W         5
`define DSOS_PERMILLE       25'h00003E8
`define DSOS_TENTHS         8'h0A
`define DSOS_CLK_MHZ        100
`define DSOS_TICK_MS        100
`define DSOS_TICK_CYCLES    (`DSOS_TICK_MS * 1000 * `DSOS_CLK_MHZ)

`endif

// file: design/dsos_pkg.sv
// Types of the drive status output selector.
// Assumes dsos_params.svh is on the include path.
`include "dsos_params.svh"

package dsos_pkg;

  // Output function codes; code 0 and codes above 18 select nothing
  typedef enum logic [`DSOS_FUNC_W-1:0] {
    FN_NOT_USED   = 5'h01,
    FN_READY      = 5'h02,
    FN_ZERO_SPD   = 5'h03,
    FN_SPD_LEVEL  = 5'h04,
    FN_SPD_ABS    = 5'h05,
    FN_ARRIVAL    = 5'h06,
    FN_TIMER      = 5'h07,
    FN_UNDERVOLT  = 5'h08,
    FN_RUN        = 5'h09,
    FN_REGEN      = 5'h0A,
    FN_MOTOR_HOT  = 5'h0B,
    FN_SINK_HOT   = 5'h0C,
    FN_AGREE      = 5'h0D,
    FN_TRQ_DET    = 5'h0E,
    FN_TRQ_LIMIT  = 5'h0F,
    FN_OVERLOAD   = 5'h10,
    FN_STOP       = 5'h11,
    FN_STEADY     = 5'h12
  } func_code_t;

  // Measurements and state from the control core, same clock
  typedef struct packed {
    logic signed [17:0] speed;      // 0.1 rpm
    logic signed [17:0] set_speed;  // 0.1 rpm
    logic signed [12:0] torque;     // 0.1 % of rated torque
    logic        [11:0] current;    // 0.1 % of motor rated current
    logic        [7:0]  motor_temp; // deg C
    logic        [7:0]  sink_temp;  // deg C
    logic        [9:0]  dc_volt;    // V
    logic               running;
    logic               trip;
    logic               regen;
    logic               accel;
    logic               decel;
    logic               trq_sat;
  } core_status_t;

endpackage : dsos_pkg

// file: design/drive_status_output_selector.sv
// Status detection and output selection for three multi-function outputs.
// Assumes a control core on i_clk_sys and a register master on the same
// clock; the timer terminal is asynchronous.
//
// Functional notes
// - Each of three outputs carries one function, codes one to eighteen.
// - Output active while its selected function is true, else inactive.
// - Code one means unused; output carries nothing.
// - Ready true while operable; drops at once on trip.
// - Zero speed: level 0..480 rpm, band percent of max speed.
// - Speed level signed compare and magnitude compare against +-3600 rpm.
// - Speed level band 0.1..10 percent of maximum motor speed.
// - Arrival: motor inside band around set speed, band programmable.
// - Agreement: speed equals set speed within hysteresis band.
// - Timer output follows terminal with rise and fall delays.
// - Undervoltage while DC-link below low-voltage alarm level.
// - Run true while inverter running.
// - Regeneration true while motor regenerating.
// - Motor overheat above level 75..150 C with hysteresis band.
// - Motor overheat only alarms; active only with thermistor input selected.
// - Heatsink overheat above level 50..85 C with band; no trip.
// - Torque detect when regulator torque reaches level, with band.
// - Torque limit true while torque reference saturated.
// - Overload compares output current with level relative to rated current.
// - Overload sets and clears only after persisting the alarm time.
// - Stop true while inverter stopped.
// - Steady true while running, neither accelerating nor decelerating.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "dsos_params.svh"

// ----------------------------------------------------------------------
// Level comparator with hysteresis
// ----------------------------------------------------------------------
module level_hyst (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic signed [19:0] i_value,
  input  wire logic signed [19:0] i_level,
  input  wire logic signed [19:0] i_band,
  input  wire logic               i_above,
  output logic                    o_flag
);
  logic signed [20:0] val_x;
  logic signed [20:0] lvl_x;
  logic signed [20:0] bnd_x;

  assign val_x = {i_value[19], i_value};
  assign lvl_x = {i_level[19], i_level};
  assign bnd_x = {i_band[19], i_band};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_above) begin
      if (val_x >= lvl_x) begin
        o_flag <= 1'b1;
      end else if (val_x < lvl_x - bnd_x) begin
        o_flag <= 1'b0;
      end
    end else begin
      if (val_x <= lvl_x) begin
        o_flag <= 1'b1;
      end else if (val_x > lvl_x + bnd_x) begin
        o_flag <= 1'b0;
      end
    end
  end
endmodule // level_hyst

// ----------------------------------------------------------------------
// Persistence timer: flag follows the condition once it has differed
// for i_target ticks; any return to agreement restarts the count
// ----------------------------------------------------------------------
module persist_timer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_cond,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_target,
  output logic             o_flag
);
  logic [15:0] cnt_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r  <= 16'h0000;
      o_flag <= 1'b0;
    end else if (i_cond == o_flag) begin
      cnt_r  <= 16'h0000;
    end else if (cnt_r >= i_target) begin
      cnt_r  <= 16'h0000;
      o_flag <= i_cond;
    end else if (i_tick) begin
      cnt_r  <= cnt_r + 16'h0001;
    end
  end
endmodule // persist_timer

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module drive_status_output_selector #(
  parameter int TICK_CYCLES = `DSOS_TICK_CYCLES
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst,
  input  wire logic [`DSOS_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  input  wire dsos_pkg::core_status_t  i_core,
  input  wire logic                    i_timer_terminal,
  output logic                         o_relay_output_one,
  output logic                         o_relay_output_two,
  output logic                         o_open_collector_output
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [31:0] select_r;
  logic [31:0] zero_spd_r;
  logic [31:0] spd_cmp_r;
  logic [31:0] bands_r;
  logic [31:0] max_spd_r;
  logic [31:0] timer_r;
  logic [31:0] temp_r;
  logic [31:0] trq_ol_r;
  logic [31:0] low_volt_r;
  logic [`DSOS_FUNC_COUNT-1:0] flags;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      select_r   <= `DSOS_RST_SELECT;
      zero_spd_r <= `DSOS_RST_ZERO_SPD;
      spd_cmp_r  <= `DSOS_RST_SPD_CMP;
      bands_r    <= `DSOS_RST_BANDS;
      max_spd_r  <= `DSOS_RST_MAX_SPD;
      timer_r    <= `DSOS_RST_TIMER;
      temp_r     <= `DSOS_RST_TEMP;
      trq_ol_r   <= `DSOS_RST_TRQ_OL;
      low_volt_r <= `DSOS_RST_LOW_VOLT;
    end else if (i_wr) begin
      case (i_addr)
        `DSOS_OFS_SELECT:   select_r   <= i_wdata;
        `DSOS_OFS_ZERO_SPD: zero_spd_r <= i_wdata;
        `DSOS_OFS_SPD_CMP:  spd_cmp_r  <= i_wdata;
        `DSOS_OFS_BANDS:    bands_r    <= i_wdata;
        `DSOS_OFS_MAX_SPD:  max_spd_r  <= i_wdata;
        `DSOS_OFS_TIMER:    timer_r    <= i_wdata;
        `DSOS_OFS_TEMP:     temp_r     <= i_wdata;
        `DSOS_OFS_TRQ_OL:   trq_ol_r   <= i_wdata;
        `DSOS_OFS_LOW_VOLT: low_volt_r <= i_wdata;
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        `DSOS_OFS_SELECT:   o_rdata <= select_r;
        `DSOS_OFS_ZERO_SPD: o_rdata <= zero_spd_r;
        `DSOS_OFS_SPD_CMP:  o_rdata <= spd_cmp_r;
        `DSOS_OFS_BANDS:    o_rdata <= bands_r;
        `DSOS_OFS_MAX_SPD:  o_rdata <= max_spd_r;
        `DSOS_OFS_TIMER:    o_rdata <= timer_r;
        `DSOS_OFS_TEMP:     o_rdata <= temp_r;
        `DSOS_OFS_TRQ_OL:   o_rdata <= trq_ol_r;
        `DSOS_OFS_LOW_VOLT: o_rdata <= low_volt_r;
        `DSOS_OFS_STATUS: begin
          o_rdata                 <= 32'h0000_0000;
          o_rdata[`DSOS_F_ST_FLAGS] <= flags;
          o_rdata[`DSOS_F_ST_OUTS]  <= {o_open_collector_output,
                                        o_relay_output_two,
                                        o_relay_output_one};
        end
        default:            o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Scaling helpers
  // --------------------------------------------------------------------
  // Band in 0.1 % of maximum speed to 0.1 rpm; a constant divider is
  // cheaper than a settable reciprocal and the band changes rarely
  function automatic logic signed [19:0] pct_of_max(
    input logic [17:0] max_spd,
    input logic [6:0]  band
  );
    logic [24:0] prod;
    prod = 25'({max_spd} * {band});
    prod = prod / `DSOS_PERMILLE;
    return {5'h00, prod[14:0]};
  endfunction

  function automatic logic signed [19:0] mag20(
    input logic signed [19:0] v
  );
    return v[19] ? -v : v;
  endfunction

  logic signed [19:0] spd_x;
  logic signed [19:0] err_x;
  logic signed [19:0] spd_abs;
  logic signed [19:0] err_abs;
  logic signed [19:0] sc_lvl;
  logic signed [19:0] zs_band;
  logic signed [19:0] sc_band;
  logic signed [19:0] arr_band;
  logic signed [19:0] agr_band;

  assign spd_x    = {{2{i_core.speed[17]}}, i_core.speed};
  assign err_x    = {{2{i_core.set_speed[17]}}, i_core.set_speed} - spd_x;
  assign spd_abs  = mag20(spd_x);
  assign err_abs  = mag20(err_x);
  assign sc_lvl   = {{2{spd_cmp_r[17]}}, spd_cmp_r[`DSOS_F_SC_LEVEL]};
  assign zs_band  = pct_of_max(max_spd_r[`DSOS_F_MAX_SPD],
                               zero_spd_r[`DSOS_F_ZS_BAND]);
  assign sc_band  = pct_of_max(max_spd_r[`DSOS_F_MAX_SPD],
                               spd_cmp_r[`DSOS_F_SC_BAND]);
  assign arr_band = pct_of_max(max_spd_r[`DSOS_F_MAX_SPD],
                               bands_r[`DSOS_F_ARR_BAND]);
  assign agr_band = pct_of_max(max_spd_r[`DSOS_F_MAX_SPD],
                               bands_r[`DSOS_F_AGR_BAND]);

  // --------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------
  logic zero_spd_flag;
  logic spd_level_flag;
  logic magnitude_speed_level_flag;
  logic arrival_flag;
  logic agree_flag;
  logic motor_hot_flag;
  logic sink_hot_flag;
  logic trq_flag;

  level_hyst u_zero (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (spd_abs),
    .i_level   ({7'h00, zero_spd_r[`DSOS_F_ZS_LEVEL]}),
    .i_band    (zs_band),
    .i_above   (1'b0),
    .o_flag    (zero_spd_flag)
  );

  // A negative level detects speeds at or beyond it in reverse
  level_hyst u_spd_signed (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (spd_x),
    .i_level   (sc_lvl),
    .i_band    (sc_band),
    .i_above   (~sc_lvl[19]),
    .o_flag    (spd_level_flag)
  );

  level_hyst u_spd_abs (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (spd_abs),
    .i_level   (mag20(sc_lvl)),
    .i_band    (sc_band),
    .i_above   (1'b1),
    .o_flag    (magnitude_speed_level_flag)
  );

  level_hyst u_arrival (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (err_abs),
    .i_level   (arr_band),
    .i_band    (arr_band),
    .i_above   (1'b0),
    .o_flag    (arrival_flag)
  );

  level_hyst u_agree (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (err_abs),
    .i_level   (agr_band),
    .i_band    (agr_band),
    .i_above   (1'b0),
    .o_flag    (agree_flag)
  );

  level_hyst u_motor_hot (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   ({12'h000, i_core.motor_temp}),
    .i_level   ({12'h000, temp_r[`DSOS_F_MH_LEVEL]}),
    .i_band    ({16'h0000, temp_r[`DSOS_F_MH_BAND]}),
    .i_above   (1'b1),
    .o_flag    (motor_hot_flag)
  );

  level_hyst u_sink_hot (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   ({12'h000, i_core.sink_temp}),
    .i_level   ({12'h000, temp_r[`DSOS_F_HH_LEVEL]}),
    .i_band    ({16'h0000, temp_r[`DSOS_F_HH_BAND]}),
    .i_above   (1'b1),
    .o_flag    (sink_hot_flag)
  );

  level_hyst u_torque (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_value   (mag20({{7{i_core.torque[12]}}, i_core.torque})),
    .i_level   ({8'h00, trq_ol_r[`DSOS_F_TRQ_LEVEL]}),
    .i_band    ({13'h0000, bands_r[`DSOS_F_TRQ_BAND]}),
    .i_above   (1'b1),
    .o_flag    (trq_flag)
  );

  // --------------------------------------------------------------------
  // Time base, timer terminal and persistence timers
  // --------------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // Terminal level is taken only once the second and third stages agree
  logic tmr_s1_r;
  logic tmr_s2_r;
  logic tmr_s3_r;
  logic tmr_in_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tmr_s1_r <= 1'b0;
      tmr_s2_r <= 1'b0;
      tmr_s3_r <= 1'b0;
      tmr_in_r <= 1'b0;
    end else begin
      tmr_s1_r <= i_timer_terminal;
      tmr_s2_r <= tmr_s1_r;
      tmr_s3_r <= tmr_s2_r;
      if (tmr_s2_r == tmr_s3_r) begin
        tmr_in_r <= tmr_s3_r;
      end
    end
  end

  logic        timer_flag;
  logic [15:0] timer_target;

  // Rising edge waits the rise delay, falling edge the fall delay
  assign timer_target = tmr_in_r ? timer_r[`DSOS_F_T_RISE]
                                 : timer_r[`DSOS_F_T_FALL];

  persist_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_cond    (tmr_in_r),
    .i_tick    (tick_r),
    .i_target  (timer_target),
    .o_flag    (timer_flag)
  );

  logic        ol_over;
  logic        ol_flag;
  logic [15:0] ol_target;

  // Level in whole percent against current in tenths of a percent
  assign ol_over   = {4'h0, i_core.current} >=
                     16'({trq_ol_r[`DSOS_F_OL_LEVEL]} * `DSOS_TENTHS);
  assign ol_target = 16'({trq_ol_r[`DSOS_F_OL_TIME]} * `DSOS_TENTHS);

  persist_timer u_overload (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_cond    (ol_over),
    .i_tick    (tick_r),
    .i_target  (ol_target),
    .o_flag    (ol_flag)
  );

  // --------------------------------------------------------------------
  // Direct status flags
  // --------------------------------------------------------------------
  logic undervoltage_warning;
  logic ready_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      undervoltage_warning <= 1'b0;
      ready_r              <= 1'b0;
    end else begin
      undervoltage_warning <= i_core.dc_volt <
                              low_volt_r[`DSOS_F_LV_LEVEL];
      ready_r              <= ~i_core.trip;
    end
  end

  logic motor_overheat_warning;
  logic heatsink_overheat_warning;

  // Warnings feed outputs only; nothing here reaches the trip path
  assign motor_overheat_warning    = motor_hot_flag &
                                     temp_r[`DSOS_F_THERM_SEL];
  assign heatsink_overheat_warning = sink_hot_flag;

  // Bit k holds function code k+1
  always_comb begin
    flags     = '0;
    flags[0]  = 1'b0;
    flags[1]  = ready_r & ~i_core.trip;
    flags[2]  = zero_spd_flag;
    flags[3]  = spd_level_flag;
    flags[4]  = magnitude_speed_level_flag;
    flags[5]  = arrival_flag & i_core.running;
    flags[6]  = timer_flag;
    flags[7]  = undervoltage_warning;
    flags[8]  = i_core.running;
    flags[9]  = i_core.regen;
    flags[10] = motor_overheat_warning;
    flags[11] = heatsink_overheat_warning;
    flags[12] = agree_flag;
    flags[13] = trq_flag;
    flags[14] = i_core.trq_sat;
    flags[15] = ol_flag;
    flags[16] = ~i_core.running;
    flags[17] = i_core.running & ~i_core.accel & ~i_core.decel;
  end

  // --------------------------------------------------------------------
  // Output selection
  // --------------------------------------------------------------------
  function automatic logic pick(
    input logic [`DSOS_FUNC_W-1:0]    code,
    input logic [`DSOS_FUNC_COUNT-1:0] f
  );
    logic hit;
    hit = 1'b0;
    if (code >= dsos_pkg::FN_NOT_USED && code <= dsos_pkg::FN_STEADY) begin
      hit = f[code - 5'h01];
    end
    return hit;
  endfunction

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_relay_output_one      <= 1'b0;
      o_relay_output_two      <= 1'b0;
      o_open_collector_output <= 1'b0;
    end else begin
      o_relay_output_one      <= pick(select_r[`DSOS_F_SEL_R1], flags);
      o_relay_output_two      <= pick(select_r[`DSOS_F_SEL_R2], flags);
      o_open_collector_output <= pick(select_r[`DSOS_F_SEL_OC], flags);
    end
  end

endmodule // drive_status_output_selector

// file: sim/dsos_props.sv
// Port checker of the status output selector.
// Assumes it is bound to drive_status_output_selector.
`timescale 1ns/10ps
module dsos_props #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic [7:0]             i_addr,
  input wire logic [31:0]            i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [31:0]            o_rdata,
  input wire dsos_pkg::core_status_t i_core,
  input wire logic                   i_timer_terminal,
  input wire logic                   o_relay_output_one,
  input wire logic                   o_relay_output_two,
  input wire logic                   o_open_collector_output
);
  logic [4:0] sel_r;
  logic       o1;
  assign o1 = o_relay_output_one;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Shadow of the first selector field
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) sel_r <= 5'h01;
    else if (i_wr && i_addr == 8'h00) sel_r <= i_wdata[4:0];
  end
  AST_UNUSED: assert property ($past(sel_r) == 5'h01 |-> !o1)
    else $error("unused output active");
  AST_RANGE: assert property (sel_r == 5'h00 || sel_r > 5'h12 |=> !o1)
    else $error("invalid code drives output");
  AST_READY: assert property (sel_r == 5'h02 && i_core.trip |=> !o1)
    else $error("ready held during trip");
  AST_RUN: assert property ((sel_r == 5'h09 && i_core.running) [*2]
    |-> o1 [*2])
    else $error("run output low");
  AST_REGEN: assert property ($past(sel_r) == 5'h0A
    |-> o1 == $past(i_core.regen))
    else $error("regen output wrong");
  AST_TRQ_LIMIT: assert property (sel_r == 5'h0F
    |=> o1 == $past(i_core.trq_sat))
    else $error("torque limit output wrong");
  AST_STOP: assert property (sel_r == 5'h11 && $fell(i_core.running)
    |=> o1)
    else $error("stop output low");
  AST_STEADY: assert property ($past(sel_r) == 5'h12
    |-> o1 == $past(i_core.running && !i_core.accel && !i_core.decel))
    else $error("steady output wrong");
  cover property (sel_r == 5'h09 && o1);
  cover property ($past(sel_r) == 5'h02 && $fell(o1));
  cover property (sel_r == 5'h07 && o1);
endmodule // dsos_props

// file: sim/dsos_partner.sv
// External wiring at the output terminals.
// Assumes the bench requests the timer terminal level.
`timescale 1ns/10ps
module dsos_partner (
  input  wire logic i_level,
  input  wire logic i_relay_one,
  input  wire logic i_relay_two,
  input  wire logic i_open_coll,
  output logic      o_timer_terminal
);
  // The contact moves out of step with the drive clock
  initial o_timer_terminal = 1'b0;
  always @(i_level) o_timer_terminal <= #3 i_level;
endmodule // dsos_partner

// file: sim/testbench.sv
// Self-checking bench of the status output selector.
// Assumes package, design, checker and partner are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
  localparam int TICK_CYCLES = 10;
  logic                   i_clk_sys = 1'b0;
  logic                   i_rst = 1'b1;
  logic [7:0]             i_addr = 8'h00;
  logic [31:0]            i_wdata = 32'h0;
  logic [31:0]            o_rdata;
  logic                   i_wr = 1'b0;
  logic                   i_rd = 1'b0;
  logic                   req = 1'b0;
  logic                   tmr, o1, o2, oc, e;
  dsos_pkg::core_status_t i_core = '0;
  int                     num_errors = 0;
  int                     comparisons = 0;
  logic [4:0] codes[15] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h08,
    5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13};
  always #5 i_clk_sys = ~i_clk_sys;
  drive_status_output_selector #(.TICK_CYCLES(TICK_CYCLES))
    drive_status_output_selector_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_core(i_core), .i_timer_terminal(tmr),
    .o_relay_output_one(o1), .o_relay_output_two(o2),
    .o_open_collector_output(oc));
  dsos_partner dsos_partner_i (.i_level(req), .i_relay_one(o1),
    .i_relay_two(o2), .i_open_coll(oc), .o_timer_terminal(tmr));
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    `CHK(o_rdata, x)
  endtask
  task automatic wait_out(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (o1 !== v && n <= hi) begin
      @(posedge i_clk_sys);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    if (n > hi) print_verdict();
  endtask
  task automatic rand_core(input int k);
    logic [95:0]            r;
    dsos_pkg::core_status_t s;
    r = {$urandom, $urandom, $urandom};
    s = r[$bits(s)-1:0];
    // Keep clear of the hysteresis bands so the outcome is fixed
    if (s.speed < 0 && s.speed > -18'sd91) s.speed = '0;
    if (s.sink_temp inside {[8'h46:8'h4A]}) s.sink_temp = 8'h4B;
    if (k < 2) s.dc_volt = 10'h190 - 10'(k);
    @(posedge i_clk_sys);
    i_core <= s;
  endtask
  function automatic logic exp_out(input logic [4:0] c,
                                   input dsos_pkg::core_status_t s);
    case (c)
      5'h02: return !s.trip;
      5'h04: return s.speed >= 0;
      5'h05, 5'h0E: return 1'b1;
      5'h08: return s.dc_volt < 10'h190;
      5'h09: return s.running;
      5'h0A: return s.regen;
      5'h0C: return s.sink_temp >= 8'h4B;
      5'h0F: return s.trq_sat;
      5'h11: return !s.running;
      5'h12: return s.running && !s.accel && !s.decel;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    void'($urandom(11136));
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(8'h00, 32'h0001_0101);
    rd(8'h18, 32'h054B_058C);
    rd(8'h1C, 32'h0A96_0000);
    rd(8'h28, 32'h0000_0000);
    $display("registers done");
    foreach (codes[i]) begin
      wr(8'h00, {11'h0, codes[i], 3'h0, codes[i], 3'h0, codes[i]});
      for (int k = 0; k < 20; k++) begin
        rand_core(k);
        repeat (4) @(posedge i_clk_sys);
        e = exp_out(codes[i], i_core);
        `CHK({o1, o2, oc}, {3{e}})
      end
      $display("code %0d done", codes[i]);
    end
    i_core <= '0;
    wr(8'h00, 32'h0001_0107);
    wr(8'h14, 32'h0002_0003);
    req <= 1'b1;
    wait_out(1'b1, 23, 40);
    req <= 1'b0;
    wait_out(1'b0, 12, 30);
    req <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    req <= 1'b0;
    repeat (60) @(posedge i_clk_sys);
    `CHK(o1, 1'b0)
    $display("timer done");
    wr(8'h00, 32'h0001_0110);
    wr(8'h1C, 32'h0196_0000);
    i_core.current <= 12'h7D0;
    wait_out(1'b1, 88, 115);
    i_core.current <= 12'h3E8;
    wait_out(1'b0, 88, 115);
    $display("overload done");
    rd(8'h24, 32'h0001_309E);
    print_verdict();
  end
endmodule // testbench
bind drive_status_output_selector dsos_props #(.TICK_CYCLES(TICK_CYCLES))
  dsos_props_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_core(i_core), .i_timer_terminal(i_timer_terminal),
  .o_relay_output_one(o_relay_output_one),
  .o_relay_output_two(o_relay_output_two),
  .o_open_collector_output(o_open_collector_output));
